// >>> src/wes_status.sv
// Wake event status low byte with enables, routing and AXI4-Lite register access
//
// Contract
// R1 - Writing one clears status bit; zero keeps
// R2 - Own serial logic wake sets bit 7
// R3 - Serial command 01h sets bit 7 always
// R4 - Bit 7 raises no control/management irq
// R5 - Software clears bit 7 before sleeping
// R6 - Watchdog control irq sets bit 6
// R7 - Codec data high, clock stopped sets 5
// R8 - Codec global flag sets bit 5 only
// R9 - USB two sets bit 4, wakes if enabled
// R10 - USB one sets bit 3, wakes if enabled
// R11 - Thermal throttle start sets bit 1
// R12 - Bit 1 raises no irq, no wake
// R13 - Active thermal pin level sets bit 0
// R14 - Enabled bit 0 raises power event irq
// R15 - Enabled status wakes; routes control/management irq (here an enabled bit 6 raises no wake)
// R16 - Only resume well reset clears status
// R17 - Polarity zero low active, one high
// R18 - Bit 2 reads zero, ignores writes
//
// The implementer's own choices: the AXI4-Lite register port and the placing of the registers.
module wes_status #(
    parameter int ADDR_W = 4,
    parameter int CODEC_IDLE = wes_pkg::CODEC_IDLE_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite slave
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Event sources
    input wire wes_pkg::wes_events_t events,
    input wire logic system_working,
    input wire logic thermal_input_pin,
    input wire logic [1:0] codec_serial_data_in,
    input wire logic codec_bit_clock,
    // Event outputs
    output logic wake_event,
    output logic acpi_system_control_irq,
    output logic system_management_irq,
    output logic irq
);
    initial
    begin
        if (ADDR_W < 4)
        begin
            $error("ADDR_W must be at least 4");
        end
    end

    // Register state
    logic [7:0] sts_ff;          // Status bits, resume well
    logic [7:0] en_ff;           // Enables, bit 2 is pin polarity
    logic routing_ff;            // Control irq routing select
    logic [7:0] nxt_sts;
    logic [7:0] nxt_en;
    logic nxt_routing;

    // Bus state
    logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
    logic aw_held_ff, w_held_ff;
    logic [3:0] waddr_ff;
    logic [31:0] wdata_ff;
    logic wstrb0_ff;             // Low byte lane strobe
    logic [1:0] bresp_ff, rresp_ff;
    logic [31:0] rdata_ff;
    logic nxt_awready, nxt_wready, nxt_bvalid, nxt_arready, nxt_rvalid;
    logic nxt_aw_held, nxt_w_held;
    logic [3:0] nxt_waddr;
    logic [31:0] nxt_wdata;
    logic nxt_wstrb0;
    logic [1:0] nxt_bresp, nxt_rresp;
    logic [31:0] nxt_rdata;

    // Event state
    logic therm_meta_ff, therm_sync_ff;  // Thermal pin synchroniser
    logic throttle_prev_ff;              // Throttle edge history
    logic wake_ff, sci_ff, smi_ff, irq_ff;
    logic nxt_wake, nxt_sci, nxt_smi, nxt_irq;

    // Combinational helpers
    logic codec_wake;
    logic therm_active;
    logic [7:0] set_vec;
    logic [7:0] clr_vec;
    logic wr_fire;
    logic irq_src;

    // True when the offset is one of the four mapped words
    function automatic logic is_mapped(input logic [3:0] ofs);
        is_mapped = (ofs == wes_pkg::OFS_STATUS) || (ofs == wes_pkg::OFS_ENABLE) ||
                    (ofs == wes_pkg::OFS_CLEAR) || (ofs == wes_pkg::OFS_CONTROL);
    endfunction

    // Codec link stall detector
    wes_codec_wake #(
        .IDLE_CYCLES(CODEC_IDLE)
    ) wes_codec_wake_inst (
        .aclk(aclk),
        .aresetn(aresetn),
        .codec_serial_data_in(codec_serial_data_in),
        .codec_bit_clock(codec_bit_clock),
        .codec_wake(codec_wake)
    );

    // Hardware set sources
    always_comb
    begin
        therm_active = en_ff[wes_pkg::BIT_POLARITY] ? therm_sync_ff : ~therm_sync_ff; // R17
        set_vec = 8'h00;
        set_vec[wes_pkg::BIT_SERIAL] = events.serial_wake_req ||                       // R2
            (events.serial_cmd_valid && events.serial_cmd_code == wes_pkg::SERIAL_WAKE_CMD); // R3
        set_vec[wes_pkg::BIT_WATCHDOG] = events.watchdog_sci;                           // R6
        set_vec[wes_pkg::BIT_CODEC] = codec_wake || events.codec_global_interrupt_flag; // R7 R8
        set_vec[wes_pkg::BIT_USB_TWO] = events.usb_host_two_wake;                       // R9
        set_vec[wes_pkg::BIT_USB_ONE] = events.usb_host_one_wake;                       // R10
        set_vec[wes_pkg::BIT_THERMAL_OVR] = events.throttle_active && !throttle_prev_ff; // R11
        set_vec[wes_pkg::BIT_THERMAL_PIN] = therm_active;                               // R13
    end

    // Write decode and register next values
    always_comb
    begin
        wr_fire = aw_held_ff && w_held_ff && !bvalid_ff;
        clr_vec = 8'h00;
        nxt_en = en_ff;
        nxt_routing = routing_ff;
        if (wr_fire && wstrb0_ff)
        begin
            unique case (waddr_ff)
                wes_pkg::OFS_STATUS, wes_pkg::OFS_CLEAR:
                begin
                    clr_vec = wdata_ff[7:0]; // R1
                end
                wes_pkg::OFS_ENABLE:
                begin
                    nxt_en = wdata_ff[7:0] & wes_pkg::EN_WR_MASK;
                end
                wes_pkg::OFS_CONTROL:
                begin
                    nxt_routing = wdata_ff[wes_pkg::BIT_ROUTING];
                end
                default:
                begin
                    clr_vec = 8'h00;
                end
            endcase
        end
        // Set wins over a clear in the same cycle; bit 2 stays zero
        nxt_sts = ((sts_ff & ~clr_vec) | set_vec) & wes_pkg::STS_IMPL_MASK; // R1 R18
    end

    // Write channel handshakes
    always_comb
    begin
        nxt_aw_held = aw_held_ff;
        nxt_waddr = waddr_ff;
        nxt_w_held = w_held_ff;
        nxt_wdata = wdata_ff;
        nxt_wstrb0 = wstrb0_ff;
        nxt_bresp = bresp_ff;
        nxt_bvalid = bvalid_ff;
        if (s_axi_awvalid && awready_ff)
        begin
            nxt_aw_held = 1'b1;
            nxt_waddr = {s_axi_awaddr[3:2], 2'h0};
        end
        if (s_axi_wvalid && wready_ff)
        begin
            nxt_w_held = 1'b1;
            nxt_wdata = s_axi_wdata;
            nxt_wstrb0 = s_axi_wstrb[0];
        end
        if (wr_fire)
        begin
            nxt_aw_held = 1'b0;
            nxt_w_held = 1'b0;
            nxt_bvalid = 1'b1;
            nxt_bresp = is_mapped(waddr_ff) ? wes_pkg::RESP_OKAY : wes_pkg::RESP_SLVERR;
        end
        else if (bvalid_ff && s_axi_bready)
        begin
            nxt_bvalid = 1'b0;
        end
        nxt_awready = !nxt_aw_held && !nxt_bvalid;
        nxt_wready = !nxt_w_held && !nxt_bvalid;
    end

    // Read channel: answer one cycle after the address is taken
    always_comb
    begin
        nxt_rdata = rdata_ff;
        nxt_rresp = rresp_ff;
        nxt_rvalid = rvalid_ff;
        if (s_axi_arvalid && arready_ff)
        begin
            nxt_rvalid = 1'b1;
            nxt_rresp = is_mapped({s_axi_araddr[3:2], 2'h0}) ? wes_pkg::RESP_OKAY : wes_pkg::RESP_SLVERR;
            unique case ({s_axi_araddr[3:2], 2'h0})
                wes_pkg::OFS_STATUS:
                begin
                    nxt_rdata = {24'h000000, sts_ff};
                end
                wes_pkg::OFS_ENABLE:
                begin
                    nxt_rdata = {24'h000000, en_ff};
                end
                wes_pkg::OFS_CONTROL:
                begin
                    nxt_rdata = {31'h00000000, routing_ff};
                end
                default:
                begin
                    nxt_rdata = 32'h00000000; // Clear word reads zero
                end
            endcase
        end
        else if (rvalid_ff && s_axi_rready)
        begin
            nxt_rvalid = 1'b0;
        end
        nxt_arready = !nxt_rvalid;
    end

    // Event outputs from current status
    always_comb
    begin
        // Bit 7 wakes with no enable; bit 1 is outside both masks
        nxt_wake = (|(sts_ff & en_ff & wes_pkg::WAKE_SRC_MASK)) || sts_ff[wes_pkg::BIT_SERIAL]; // R9 R10 R12 R15
        irq_src = |(sts_ff & en_ff & wes_pkg::IRQ_SRC_MASK); // R4 R12 R14
        nxt_sci = system_working && routing_ff && irq_src;   // R15
        nxt_smi = system_working && !routing_ff && irq_src;  // R15
        nxt_irq = irq_src;
    end

    // State registers; status clears only on the resume well reset
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sts_ff <= wes_pkg::STS_RESET; // R16
            en_ff <= wes_pkg::EN_RESET;
            routing_ff <= 1'b0;
            awready_ff <= 1'b0;
            wready_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b0;
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            waddr_ff <= 4'h0;
            wdata_ff <= 32'h00000000;
            wstrb0_ff <= 1'b0;
            bresp_ff <= wes_pkg::RESP_OKAY;
            rresp_ff <= wes_pkg::RESP_OKAY;
            rdata_ff <= 32'h00000000;
            therm_meta_ff <= 1'b1; // Inactive level under reset polarity
            therm_sync_ff <= 1'b1;
            throttle_prev_ff <= 1'b0;
            wake_ff <= 1'b0;
            sci_ff <= 1'b0;
            smi_ff <= 1'b0;
            irq_ff <= 1'b0;
        end
        else
        begin
            sts_ff <= nxt_sts;
            en_ff <= nxt_en;
            routing_ff <= nxt_routing;
            awready_ff <= nxt_awready;
            wready_ff <= nxt_wready;
            bvalid_ff <= nxt_bvalid;
            arready_ff <= nxt_arready;
            rvalid_ff <= nxt_rvalid;
            aw_held_ff <= nxt_aw_held;
            w_held_ff <= nxt_w_held;
            waddr_ff <= nxt_waddr;
            wdata_ff <= nxt_wdata;
            wstrb0_ff <= nxt_wstrb0;
            bresp_ff <= nxt_bresp;
            rresp_ff <= nxt_rresp;
            rdata_ff <= nxt_rdata;
            therm_meta_ff <= thermal_input_pin;
            therm_sync_ff <= therm_meta_ff;
            throttle_prev_ff <= events.throttle_active;
            wake_ff <= nxt_wake;
            sci_ff <= nxt_sci;
            smi_ff <= nxt_smi;
            irq_ff <= nxt_irq;
        end
    end

    // Port drive
    assign s_axi_awready = awready_ff;
    assign s_axi_wready = wready_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign wake_event = wake_ff;
    assign acpi_system_control_irq = sci_ff;
    assign system_management_irq = smi_ff;
    assign irq = irq_ff;

    // Checks
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    chk_w1c_clear: assert property ( // R1
        wr_fire && wstrb0_ff && waddr_ff == wes_pkg::OFS_STATUS && wdata_ff[3] && !set_vec[3] |=> !sts_ff[3])
        else $error("status bit not cleared by write of one");
    chk_serial_cmd: assert property ( // R3
        events.serial_cmd_valid && events.serial_cmd_code == wes_pkg::SERIAL_WAKE_CMD |=> sts_ff[7])
        else $error("serial wake command did not set bit 7");
    chk_no_irq_quiet: assert property ( // R4
        (sts_ff & en_ff & wes_pkg::IRQ_SRC_MASK) == 8'h00 |=> !acpi_system_control_irq && !system_management_irq)
        else $error("irq raised without enabled source");
    chk_watchdog_set: assert property ( // R6
        events.watchdog_sci |=> sts_ff[6])
        else $error("watchdog event lost");
    chk_codec_flag: assert property ( // R8
        events.codec_global_interrupt_flag |=> sts_ff[5])
        else $error("codec global flag did not set bit 5");
    chk_usb_wake: assert property ( // R9
        sts_ff[4] && en_ff[4] |=> wake_event)
        else $error("usb two wake not produced");
    chk_throttle_edge: assert property ( // R11
        events.throttle_active && !$past(events.throttle_active) |=> sts_ff[1])
        else $error("throttle start did not set bit 1");
    chk_override_silent: assert property ( // R12
        sts_ff == 8'h02 ##1 sts_ff == 8'h02 |-> !wake_event && !irq)
        else $error("override bit raised an event");
    chk_thermal_pin: assert property ( // R13
        therm_active |=> sts_ff[0])
        else $error("active thermal pin did not set bit 0");
    chk_route_sci: assert property ( // R15
        system_working && routing_ff && irq_src |=> acpi_system_control_irq && !system_management_irq)
        else $error("control irq routing wrong");
    chk_reserved_zero: assert property ( // R18
        sts_ff[2] == 1'b0)
        else $error("reserved bit 2 set");
endmodule

// >>> src/wes_pkg.sv
// Package: register map, status bit layout and event carrier for the wake event status block
package wes_pkg;
    // Register byte offsets (low address bits)
    localparam logic [3:0] OFS_STATUS = 4'h0;
    localparam logic [3:0] OFS_ENABLE = 4'h4;
    localparam logic [3:0] OFS_CLEAR = 4'h8;
    localparam logic [3:0] OFS_CONTROL = 4'hC;
    // Status bit positions; polarity is an enable bit, routing a control bit
    localparam int BIT_THERMAL_PIN = 0;
    localparam int BIT_THERMAL_OVR = 1;
    localparam int BIT_POLARITY = 2;
    localparam int BIT_USB_ONE = 3;
    localparam int BIT_USB_TWO = 4;
    localparam int BIT_CODEC = 5;
    localparam int BIT_WATCHDOG = 6;
    localparam int BIT_SERIAL = 7;
    localparam int BIT_ROUTING = 0;
    // Field masks
    localparam logic [7:0] STS_IMPL_MASK = 8'hFB;
    localparam logic [7:0] EN_WR_MASK = 8'h7D;
    localparam logic [7:0] IRQ_SRC_MASK = 8'h79;
    localparam logic [7:0] WAKE_SRC_MASK = 8'h39;
    localparam logic [7:0] STS_RESET = 8'h00;
    localparam logic [7:0] EN_RESET = 8'h00;
    // Serial slave wake/interrupt command code
    localparam logic [7:0] SERIAL_WAKE_CMD = 8'h01;
    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Cycles without a bit clock edge before the codec link counts as stopped
    localparam int CODEC_IDLE_CYCLES = 16;

    // Same-clock event sources from neighbouring logic
    typedef struct packed {
        logic serial_wake_req;      // Own serial logic wake request, pulse
        logic serial_cmd_valid;     // Serial slave command received, pulse
        logic [7:0] serial_cmd_code;
        logic watchdog_sci;         // Watchdog logic raises control irq, pulse
        logic codec_global_interrupt_flag;
        logic usb_host_two_wake;    // Controller two wake request
        logic usb_host_one_wake;    // Controller one wake request
        logic throttle_active;      // Thermal override throttling, level
    } wes_events_t;
endpackage

// >>> src/wes_codec_wake.sv
// Codec wake detector: data line high while the bit clock stands still
module wes_codec_wake #(
    parameter int IDLE_CYCLES = wes_pkg::CODEC_IDLE_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [1:0] codec_serial_data_in,
    input wire logic codec_bit_clock,
    output logic codec_wake
);
    localparam int CW = $clog2(IDLE_CYCLES + 1);
    localparam logic [CW-1:0] IDLE_MAX = CW'(IDLE_CYCLES);

    initial
    begin
        if (IDLE_CYCLES < 2)
        begin
            $error("IDLE_CYCLES must be at least 2");
        end
    end

    logic [1:0] sdin_meta_ff;    // First sync stage, data
    logic [1:0] sdin_sync_ff;    // Second sync stage, data
    logic bclk_meta_ff;          // First sync stage, bit clock
    logic bclk_sync_ff;          // Second sync stage, bit clock
    logic bclk_prev_ff;          // Edge detect history
    logic [CW-1:0] idle_cnt_ff;  // Cycles since last bit clock edge
    logic codec_wake_ff;
    logic [CW-1:0] nxt_idle_cnt;
    logic nxt_codec_wake;

    // Count quiet cycles; wake when stopped and a data line is high
    always_comb
    begin
        if (bclk_sync_ff != bclk_prev_ff)
        begin
            nxt_idle_cnt = '0;
        end
        else if (idle_cnt_ff != IDLE_MAX)
        begin
            nxt_idle_cnt = idle_cnt_ff + CW'(1);
        end
        else
        begin
            nxt_idle_cnt = idle_cnt_ff;
        end
        nxt_codec_wake = (idle_cnt_ff == IDLE_MAX) && (|sdin_sync_ff);
    end

    // Synchronisers and detector state
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sdin_meta_ff <= 2'h0;
            sdin_sync_ff <= 2'h0;
            bclk_meta_ff <= 1'b0;
            bclk_sync_ff <= 1'b0;
            bclk_prev_ff <= 1'b0;
            idle_cnt_ff <= '0;
            codec_wake_ff <= 1'b0;
        end
        else
        begin
            sdin_meta_ff <= codec_serial_data_in;
            sdin_sync_ff <= sdin_meta_ff;
            bclk_meta_ff <= codec_bit_clock;
            bclk_sync_ff <= bclk_meta_ff;
            bclk_prev_ff <= bclk_sync_ff;
            idle_cnt_ff <= nxt_idle_cnt;
            codec_wake_ff <= nxt_codec_wake;
        end
    end

    assign codec_wake = codec_wake_ff;
endmodule

// >>> sim/wes_status_tb.sv
// Self-checking testbench for the wake event status block
module wes_status_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic aclk; // 50 MHz clock
    logic aresetn; // Resume-well reset, active low
    logic [3:0] s_axi_awaddr, s_axi_araddr; // Bus addresses
    logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready; // Master handshakes
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid; // Slave handshakes
    logic [31:0] s_axi_wdata, s_axi_rdata; // Bus data
    logic [3:0] s_axi_wstrb; // Byte strobes
    logic [1:0] s_axi_bresp, s_axi_rresp; // Bus responses
    wes_pkg::wes_events_t ev; // Event sources
    logic system_working, thermal_input_pin, codec_bit_clock; // Side inputs
    logic [1:0] codec_serial_data_in; // Codec data lines
    logic wake_event, acpi_system_control_irq, system_management_irq, irq; // Event outputs
    int mismatches; // Mismatch counter
    int cmp_count; // Comparison counter
    // Offset aliases
    localparam logic [3:0] STS = wes_pkg::OFS_STATUS;
    localparam logic [3:0] ENA = wes_pkg::OFS_ENABLE;
    localparam logic [3:0] CLR = wes_pkg::OFS_CLEAR;
    localparam logic [3:0] CTL = wes_pkg::OFS_CONTROL;

    // Device under test with a short codec idle count
    wes_status #(.ADDR_W(4), .CODEC_IDLE(4)) wes_status_inst (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .events(ev),
        .system_working(system_working), .thermal_input_pin(thermal_input_pin),
        .codec_serial_data_in(codec_serial_data_in), .codec_bit_clock(codec_bit_clock),
        .wake_event(wake_event), .acpi_system_control_irq(acpi_system_control_irq),
        .system_management_irq(system_management_irq), .irq(irq)
    );

    // Clock generator, 20 ns period
    initial
    begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end

    // Prints counts and the verdict, then ends the run
    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Compares one value and reports a mismatch at once
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmp_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // Bus write: address and data offered together, each released when taken
    task automatic axi_write(input logic [3:0] a, input logic [31:0] d);
        logic aw_done, w_done;
        int n;
        aw_done = 1'b0;
        w_done = 1'b0;
        n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!(aw_done && w_done) && n < 100)
        begin
            @(posedge aclk);
            n++;
            if (!aw_done && s_axi_awready === 1'b1)
            begin
                aw_done = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_done && s_axi_wready === 1'b1)
            begin
                w_done = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        // Wait for the response, bready high
        do
        begin
            @(posedge aclk);
            n++;
        end
        while (s_axi_bvalid !== 1'b1 && n < 200);
        check(n < 200, 1, "write response");
        check(s_axi_bresp, wes_pkg::RESP_OKAY, "bresp");
    endtask

    // Bus read of one word, compared against an expected value
    task automatic read_chk(input logic [3:0] a, input logic [31:0] exp);
        int n;
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do
        begin
            @(posedge aclk);
            n++;
        end
        while (s_axi_arready !== 1'b1 && n < 100);
        s_axi_arvalid <= 1'b0;
        while (s_axi_rvalid !== 1'b1 && n < 200)
        begin
            @(posedge aclk);
            n++;
        end
        check(n < 200, 1, "read response");
        check(s_axi_rresp, wes_pkg::RESP_OKAY, "rresp");
        check(s_axi_rdata, exp, "read data");
    endtask

    // Compares wake, control irq, management irq and irq after outputs settle
    task automatic expect_out(input logic [3:0] exp);
        repeat (2) @(posedge aclk);
        check({28'h0, wake_event, acpi_system_control_irq, system_management_irq, irq}, {28'h0, exp}, "outputs");
    endtask

    // Drives one event pattern for one cycle
    task automatic pulse_ev(input wes_pkg::wes_events_t e);
        ev <= e;
        @(posedge aclk);
        ev <= '0;
        repeat (3) @(posedge aclk);
    endtask

    // Reset values of every register and output
    task automatic t_reset();
        read_chk(STS, 32'h0);
        read_chk(ENA, 32'h0);
        read_chk(CLR, 32'h0);
        read_chk(CTL, 32'h0);
        expect_out(4'h0);
    endtask

    // Serial wake: own logic and command, no irq, write-one clear
    task automatic t_serial();
        wes_pkg::wes_events_t e;
        system_working <= 1'b1;
        axi_write(ENA, 32'h79);
        axi_write(CTL, 32'h1);
        e = '0;
        e.serial_wake_req = 1'b1;
        pulse_ev(e);
        read_chk(STS, 32'h80);
        expect_out(4'h8);
        axi_write(STS, 32'h00);
        read_chk(STS, 32'h80);
        axi_write(STS, 32'h80);
        read_chk(STS, 32'h00);
        e = '0;
        e.serial_cmd_valid = 1'b1;
        e.serial_cmd_code = 8'h02;
        pulse_ev(e);
        read_chk(STS, 32'h00);
        e.serial_cmd_code = wes_pkg::SERIAL_WAKE_CMD;
        pulse_ev(e);
        read_chk(STS, 32'h80);
        axi_write(CLR, 32'h80);
        read_chk(STS, 32'h00);
    endtask

    // Watchdog bit: routing, working state, mask and clear of the irq
    task automatic t_watchdog();
        wes_pkg::wes_events_t e;
        axi_write(ENA, 32'h40);
        e = '0;
        e.watchdog_sci = 1'b1;
        pulse_ev(e);
        read_chk(STS, 32'h40);
        expect_out(4'h5);
        axi_write(CTL, 32'h0);
        expect_out(4'h3);
        system_working <= 1'b0;
        expect_out(4'h1);
        axi_write(ENA, 32'h00);
        expect_out(4'h0);
        axi_write(STS, 32'h40);
        read_chk(STS, 32'h00);
    endtask

    // USB wake bits: set always, wake only when enabled
    task automatic t_usb();
        wes_pkg::wes_events_t e;
        axi_write(ENA, 32'h08);
        e = '0;
        e.usb_host_two_wake = 1'b1;
        pulse_ev(e);
        read_chk(STS, 32'h10);
        expect_out(4'h0);
        e = '0;
        e.usb_host_one_wake = 1'b1;
        pulse_ev(e);
        read_chk(STS, 32'h18);
        expect_out(4'h9);
        axi_write(STS, 32'h18);
        read_chk(STS, 32'h00);
    endtask

    // Codec bit: global flag, then each data line with the clock stopped
    task automatic t_codec();
        wes_pkg::wes_events_t e;
        axi_write(ENA, 32'h20);
        e = '0;
        e.codec_global_interrupt_flag = 1'b1;
        pulse_ev(e);
        read_chk(STS, 32'h20);
        expect_out(4'h9);
        axi_write(STS, 32'h20);
        for (int i = 0; i < 2; i++)
        begin
            // Clock runs first, then the line rises: no wake
            repeat (20)
            begin
                @(posedge aclk);
                codec_bit_clock <= ~codec_bit_clock;
                if (codec_bit_clock)
                    codec_serial_data_in <= 2'(1 << i);
            end
            read_chk(STS, 32'h00);
            repeat (20) @(posedge aclk);
            read_chk(STS, 32'h20);
            codec_serial_data_in <= 2'b00;
            repeat (4) @(posedge aclk);
            axi_write(STS, 32'h20);
        end
    endtask

    // Throttle start sets bit 1 with no wake or irq
    task automatic t_throttle();
        system_working <= 1'b1;
        axi_write(ENA, 32'h79);
        ev.throttle_active <= 1'b1;
        repeat (3) @(posedge aclk);
        read_chk(STS, 32'h02);
        expect_out(4'h0);
        axi_write(STS, 32'h02);
        read_chk(STS, 32'h00);
        ev.throttle_active <= 1'b0;
    endtask

    // Thermal pin with both polarities, enabled and masked
    task automatic t_thermal();
        axi_write(CTL, 32'h1);
        axi_write(ENA, 32'h01);
        read_chk(STS, 32'h00);
        thermal_input_pin <= 1'b0;
        repeat (8) @(posedge aclk);
        read_chk(STS, 32'h01);
        expect_out(4'hD);
        thermal_input_pin <= 1'b1;
        repeat (8) @(posedge aclk);
        axi_write(STS, 32'h01);
        read_chk(STS, 32'h00);
        axi_write(ENA, 32'h04);
        repeat (8) @(posedge aclk);
        read_chk(STS, 32'h01);
        expect_out(4'h0);
        axi_write(ENA, 32'h00);
        axi_write(STS, 32'h01);
        read_chk(STS, 32'h00);
    endtask

    // Reserved enable and status bits, then a mid-run reset
    task automatic t_reserved_reset();
        axi_write(ENA, 32'hFF);
        read_chk(ENA, 32'h7D);
        axi_write(ENA, 32'h00);
        axi_write(STS, 32'hFF);
        read_chk(STS, 32'h00);
        ev.usb_host_one_wake <= 1'b1;
        @(posedge aclk);
        ev.usb_host_one_wake <= 1'b0;
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        read_chk(STS, 32'h00);
    endtask

    // Watchdog against a hung run
    initial
    begin
        repeat (20000) @(posedge aclk);
        mismatches++;
        $display("Error at %0t: timeout", $time);
        finish_test();
    end

    // Main sequence
    initial
    begin
        mismatches = 0;
        cmp_count = 0;
        aresetn = 1'b0;
        s_axi_awaddr = 4'h0;
        s_axi_araddr = 4'h0;
        s_axi_awvalid = 1'b0;
        s_axi_wvalid = 1'b0;
        s_axi_arvalid = 1'b0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hF;
        s_axi_bready = 1'b1;
        s_axi_rready = 1'b1;
        ev = '0;
        system_working = 1'b0;
        thermal_input_pin = 1'b1;
        codec_bit_clock = 1'b0;
        codec_serial_data_in = 2'b00;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        t_reset();
        t_serial();
        t_watchdog();
        t_usb();
        t_codec();
        t_throttle();
        t_thermal();
        t_reserved_reset();
        finish_test();
    end
endmodule
